// [design/umaf_dev.sv]
// addressed node: apb registers, receiver with address filter, transmitter
// assumes apb master per amba rules; rem_txd is asynchronous to pclk
`timescale 1ns/1ps
module umaf_dev #(
  parameter int DIV_W = 12
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  umaf_link_if.dev         link
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} umaf_rx_e;

  logic             filt_reg, dspd_reg, rxen_reg, txen_reg, stop_reg;
  logic             par_reg, podd_reg, tx9_reg;
  logic [2:0]       size_reg;
  logic [DIV_W-1:0] baud_reg;
  logic             rxc_reg, txc_reg, udre_reg, fe_reg, dor_reg, upe_reg, rx9_reg;
  logic [7:0]       rxd_reg;
  logic [8:0]       txb_reg;
  logic [31:0]      prdata_reg;
  logic [31:0]      rdata;
  logic             hit, acc, wr, rd_pop;
  logic [DIV_W-1:0] div_reg;
  logic             tick;
  logic [4:0]       spb, sf;
  logic [3:0]       nch, nrx;
  logic             nine;

  assign acc     = psel & penable;
  assign wr      = acc & pwrite & hit;
  assign rd_pop  = acc & ~pwrite & (paddr == umaf_pkg::OFS_DATA);
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata  = prdata_reg;
  assign spb  = dspd_reg ? umaf_pkg::S_DBL : umaf_pkg::S_NORM;
  assign sf   = dspd_reg ? umaf_pkg::SF_DBL : umaf_pkg::SF_NORM;
  assign nch  = umaf_pkg::char_bits(size_reg);
  assign nrx  = nch + {3'h0, par_reg};
  assign nine = (size_reg == umaf_pkg::SIZE_9);
  assign tick = (div_reg == baud_reg);

  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0;
    if (paddr == umaf_pkg::OFS_CSA) begin
      rdata[umaf_pkg::A_FILT] = filt_reg;
      rdata[umaf_pkg::A_DSPD] = dspd_reg;
      rdata[umaf_pkg::A_UPE]  = upe_reg;
      rdata[umaf_pkg::A_DOR]  = dor_reg;
      rdata[umaf_pkg::A_FE]   = fe_reg;
      rdata[umaf_pkg::A_UDRE] = udre_reg;
      rdata[umaf_pkg::A_TXC]  = txc_reg;
      rdata[umaf_pkg::A_RXC]  = rxc_reg;
    end else if (paddr == umaf_pkg::OFS_CSB) begin
      rdata[umaf_pkg::B_TX9]  = tx9_reg;
      rdata[umaf_pkg::B_RX9]  = rx9_reg;
      rdata[umaf_pkg::B_RXEN] = rxen_reg;
      rdata[umaf_pkg::B_TXEN] = txen_reg;
      rdata[umaf_pkg::B_SIZE +: 3] = size_reg;
      rdata[umaf_pkg::B_STOP] = stop_reg;
      rdata[umaf_pkg::B_PAR]  = par_reg;
      rdata[umaf_pkg::B_PODD] = podd_reg;
    end else if (paddr == umaf_pkg::OFS_DATA) begin
      rdata[7:0] = rxd_reg;
    end else if (paddr == umaf_pkg::OFS_BAUD) begin
      rdata[DIV_W-1:0] = baud_reg;
    end else begin
      hit = 1'b0;
    end
  end

  // read data sampled in the setup cycle so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_reg <= 32'h0;
    else if (psel & ~penable) prdata_reg <= rdata;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_reg <= 1'b0;
      dspd_reg <= 1'b0;
      tx9_reg  <= 1'b0;
      rxen_reg <= 1'b0;
      txen_reg <= 1'b0;
      size_reg <= umaf_pkg::SIZE_RST;
      stop_reg <= 1'b0;
      par_reg  <= 1'b0;
      podd_reg <= 1'b0;
      baud_reg <= umaf_pkg::BAUD_RST;
    end else if (wr) begin
      if (paddr == umaf_pkg::OFS_CSA) begin
        filt_reg <= pwdata[umaf_pkg::A_FILT];
        dspd_reg <= pwdata[umaf_pkg::A_DSPD];
      end else if (paddr == umaf_pkg::OFS_CSB) begin
        tx9_reg  <= pwdata[umaf_pkg::B_TX9];
        rxen_reg <= pwdata[umaf_pkg::B_RXEN];
        txen_reg <= pwdata[umaf_pkg::B_TXEN];
        size_reg <= pwdata[umaf_pkg::B_SIZE +: 3];
        stop_reg <= pwdata[umaf_pkg::B_STOP];
        par_reg  <= pwdata[umaf_pkg::B_PAR];
        podd_reg <= pwdata[umaf_pkg::B_PODD];
      end else if (paddr == umaf_pkg::OFS_BAUD) begin
        baud_reg <= pwdata[DIV_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_reg <= '0;
    else if (tick) div_reg <= '0;
    else div_reg <= div_reg + 1'b1;
  end

  // receiver
  logic       s1_reg, s2_reg;
  umaf_rx_e   rst_reg;
  logic [4:0] rcnt_reg;
  logic [1:0] vb_reg;
  logic [3:0] ridx_reg;
  logic [9:0] rsh_reg;
  logic       maj, decide, bnd, done, ftype, store, pexp;
  logic [8:0] dmask;

  assign maj    = (vb_reg[1] & vb_reg[0]) | (vb_reg[1] & s2_reg) | (vb_reg[0] & s2_reg);
  assign decide = tick & (rcnt_reg == sf + 5'h02);
  assign bnd    = tick & (rcnt_reg == spb);
  assign done   = decide & (rst_reg == RX_STOP);
  assign ftype  = nine ? rsh_reg[8] : maj;
  assign store  = done & ~(filt_reg & ~ftype);
  assign dmask  = 9'h1ff >> (4'h9 - nch);
  assign pexp   = ^(rsh_reg[8:0] & dmask) ^ podd_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      s1_reg <= link.rem_txd;
      s2_reg <= s1_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_reg  <= RX_IDLE;
      rcnt_reg <= 5'h00;
      vb_reg   <= 2'h0;
      ridx_reg <= 4'h0;
      rsh_reg  <= 10'h000;
    end else if (!rxen_reg) begin
      rst_reg <= RX_IDLE; // disable drops a frame in flight
    end else if (tick) begin
      rcnt_reg <= (rcnt_reg == spb) ? 5'h01 : rcnt_reg + 5'h01;
      if (rcnt_reg >= sf) vb_reg <= {vb_reg[0], s2_reg};
      case (rst_reg)
        RX_IDLE: begin
          rcnt_reg <= 5'h02;
          if (!s2_reg) rst_reg <= RX_START;
          else rcnt_reg <= 5'h01;
        end
        RX_START: begin
          if (decide && maj) rst_reg <= RX_IDLE; // noise spike
          if (bnd) begin
            rst_reg  <= RX_BITS;
            ridx_reg <= 4'h0;
          end
        end
        RX_BITS: begin
          if (decide) rsh_reg[ridx_reg] <= maj;
          if (bnd) begin
            ridx_reg <= ridx_reg + 4'h1;
            if (ridx_reg == nrx - 4'h1) rst_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          // early next start allowed right after the vote
          if (decide) rst_reg <= RX_IDLE;
        end
        default: rst_reg <= RX_IDLE;
      endcase
    end
  end

  // single-entry buffer; a store while full and not read in that cycle is lost and flagged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxc_reg <= 1'b0;
      fe_reg  <= 1'b0;
      dor_reg <= 1'b0;
      upe_reg <= 1'b0;
      rx9_reg <= 1'b0;
      rxd_reg <= 8'h00;
    end else if (!rxen_reg) begin
      rxc_reg <= 1'b0;
      fe_reg  <= 1'b0;
      dor_reg <= 1'b0;
      upe_reg <= 1'b0;
    end else if (store && rxc_reg && !rd_pop) begin
      dor_reg <= 1'b1;
    end else if (store) begin
      rxc_reg <= 1'b1;
      rxd_reg <= rsh_reg[7:0] & dmask[7:0];
      rx9_reg <= nine & rsh_reg[8];
      fe_reg  <= ~maj;
      upe_reg <= par_reg & (rsh_reg[nch] != pexp);
      dor_reg <= 1'b0;
    end else if (rd_pop) begin
      rxc_reg <= 1'b0;
      fe_reg  <= 1'b0;
      dor_reg <= 1'b0;
      upe_reg <= 1'b0;
    end
  end

  // transmitter; frame shape never looks at filt_reg
  logic        tbusy_reg;
  logic [12:0] tsh_reg;
  logic [3:0]  tleft_reg;
  logic [4:0]  tcnt_reg;
  logic        tload, tend;

  assign tload = ~tbusy_reg & ~udre_reg;
  assign tend  = tbusy_reg & tick & (tcnt_reg == spb - 5'h01) & (tleft_reg == 4'h1);
  assign link.dev_txd = tsh_reg[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      udre_reg <= 1'b1;
      txb_reg  <= 9'h000;
    end else if (tload) begin
      udre_reg <= 1'b1;
    end else if (wr && paddr == umaf_pkg::OFS_DATA && udre_reg && txen_reg) begin
      udre_reg <= 1'b0;
      txb_reg  <= {tx9_reg, pwdata[7:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbusy_reg <= 1'b0;
      tsh_reg   <= 13'h1fff;
      tleft_reg <= 4'h0;
      tcnt_reg  <= 5'h00;
    end else if (tload) begin
      tbusy_reg <= 1'b1;
      tsh_reg   <= umaf_pkg::frame_bits(txb_reg, nch, par_reg, podd_reg, 1'b1);
      tleft_reg <= nch + {3'h0, par_reg} + 4'h2 + {3'h0, stop_reg};
      tcnt_reg  <= 5'h00;
    end else if (tbusy_reg && tick) begin
      if (tcnt_reg == spb - 5'h01) begin
        tcnt_reg  <= 5'h00;
        tsh_reg   <= {1'b1, tsh_reg[12:1]};
        tleft_reg <= tleft_reg - 4'h1;
        if (tleft_reg == 4'h1) tbusy_reg <= 1'b0;
      end else begin
        tcnt_reg <= tcnt_reg + 5'h01;
      end
    end
  end

  // set wins over the write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) txc_reg <= 1'b0;
    else if (tend && udre_reg) txc_reg <= 1'b1;
    else if (wr && paddr == umaf_pkg::OFS_CSA && pwdata[umaf_pkg::A_TXC]) txc_reg <= 1'b0;
  end
endmodule // umaf_dev

// [design/umaf_pkg.sv]
// constants and helpers shared by both ends of the multidrop serial link
// assumes one system clock; sample tick = baud rate times samples per bit
// How it works
// - sixteen samples per bit, eight in double speed
// - vote at samples 8,9,10 or 4,5,6
// - payload of 5 to 10 bits handled
// - sender rate kept inside receiver window
// - rate error split equally between both sides
// - software picks divisor with small rate error
// - filter mode drops data frames entirely
// - transmitter ignores filter mode
// - 5-8 bits: first stop bit is type
// - nine bits: ninth bit is type
// - type one is address, zero is data
// - master sets ninth bit for address frames
// - slaves also use nine bit format
// - address frames stored, receive flag set
// - software reads address, clears filter if selected
// - filter clear accepts all data frames
// - after last data, software sets filter again
// - one char size for both directions
// - 5-8 bit sender uses two stop bits; the node's transmitter adds the second only when stop_reg is set
// - no read-modify-write on filter bit
// - writing one clears transmit complete flag
// - bit value is majority of three samples
package umaf_pkg;
  localparam logic [7:0] OFS_CSA  = 8'h00;
  localparam logic [7:0] OFS_CSB  = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_BAUD = 8'h0c;
  // ctrl_status_a fields
  localparam int A_FILT = 0;
  localparam int A_DSPD = 1;
  localparam int A_UPE  = 2;
  localparam int A_DOR  = 3;
  localparam int A_FE   = 4;
  localparam int A_UDRE = 5;
  localparam int A_TXC  = 6;
  localparam int A_RXC  = 7;
  // ctrl_b fields
  localparam int B_TX9  = 0;
  localparam int B_RX9  = 1;
  localparam int B_RXEN = 2;
  localparam int B_TXEN = 3;
  localparam int B_SIZE = 4;
  localparam int B_STOP = 7;
  localparam int B_PAR  = 8;
  localparam int B_PODD = 9;
  localparam logic [2:0]  SIZE_RST = 3'h3;
  localparam logic [2:0]  SIZE_9   = 3'h7;
  localparam logic [11:0] BAUD_RST = 12'h000;
  localparam logic [4:0]  S_NORM   = 5'h10;
  localparam logic [4:0]  S_DBL    = 5'h08;
  localparam logic [4:0]  SF_NORM  = 5'h08;
  localparam logic [4:0]  SF_DBL   = 5'h04;

  // character bits: codes 0..3 give 5..8, code 7 gives 9, others read as 8
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    if (code == SIZE_9) return 4'h9;
    else if (code < 3'h4) return 4'h5 + {1'b0, code};
    else return 4'h8;
  endfunction

  // frame lsb first: start, data, parity, stop bits (first stop given)
  function automatic logic [12:0] frame_bits(input logic [8:0] d, input logic [3:0] nch,
                                             input logic par, input logic podd,
                                             input logic stop1);
    logic [12:0] f;
    logic        p;
    f = 13'h1fff;
    p = podd;
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nch)) begin
        f[i + 1] = d[i];
        p = p ^ d[i];
      end
    end
    if (par) begin
      f[nch + 4'h1] = p;
      f[nch + 4'h2] = stop1;
    end else begin
      f[nch + 4'h1] = stop1;
    end
    return f;
  endfunction
endpackage

// [design/umaf_link_if.sv]
// serial line between the addressed node and the remote sender
// the bench reads dev_txd; the wired bus itself is outside these ends
`timescale 1ns/1ps
interface umaf_link_if;
  logic dev_txd;
  logic rem_txd;
  modport dev (input rem_txd, output dev_txd);
  modport rem (output rem_txd);
endinterface // umaf_link_if

// [design/umaf_rem.sv]
// remote sending node: frames words onto the line with type marking
// assumes user holds config stable while send_ready is low
`timescale 1ns/1ps
module umaf_rem #(
  parameter int DIV_W = 12
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [2:0]       cfg_size,
  input  wire logic             cfg_dspd,
  input  wire logic             cfg_par,
  input  wire logic             cfg_podd,
  input  wire logic             cfg_stop2,
  input  wire logic [DIV_W-1:0] cfg_div,
  input  wire logic             send_valid,
  output logic                  send_ready,
  input  wire logic [8:0]       send_data,
  input  wire logic             send_addr,
  umaf_link_if.rem              link
);
  logic [DIV_W-1:0] div_reg;
  logic             tick;
  logic             busy_reg;
  logic [12:0]      sh_reg;
  logic [3:0]       left_reg;
  logic [4:0]       tcnt_reg;
  logic [4:0]       spb;
  logic [3:0]       nch;
  logic             nine;
  logic [8:0]       dword;
  logic             two;

  assign tick = (div_reg == cfg_div);
  assign spb  = cfg_dspd ? umaf_pkg::S_DBL : umaf_pkg::S_NORM;
  assign nch  = umaf_pkg::char_bits(cfg_size);
  assign nine = (cfg_size == umaf_pkg::SIZE_9);
  assign dword = nine ? {send_addr, send_data[7:0]} : send_data;
  assign two  = cfg_stop2 | ~nine;
  assign send_ready = ~busy_reg;
  assign link.rem_txd = sh_reg[0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) div_reg <= '0;
    else if (tick) div_reg <= '0;
    else div_reg <= div_reg + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      sh_reg   <= 13'h1fff;
      left_reg <= 4'h0;
      tcnt_reg <= 5'h00;
    end else if (!busy_reg) begin
      if (send_valid) begin
        busy_reg <= 1'b1;
        // 5-8 bits: first stop carries the type, second is a real stop
        sh_reg   <= umaf_pkg::frame_bits(dword, nch, cfg_par, cfg_podd,
                                         nine | send_addr);
        left_reg <= nch + {3'h0, cfg_par} + 4'h2 + {3'h0, two};
        tcnt_reg <= 5'h00;
      end
    end else if (tick) begin
      if (tcnt_reg == spb - 5'h01) begin
        tcnt_reg <= 5'h00;
        sh_reg   <= {1'b1, sh_reg[12:1]};
        left_reg <= left_reg - 4'h1;
        if (left_reg == 4'h1) busy_reg <= 1'b0;
      end else begin
        tcnt_reg <= tcnt_reg + 5'h01;
      end
    end
  end
endmodule // umaf_rem

// [bench/umaf_properties.sv]
// checker on the joined link, the sender's user side and the node's apb side
// assumes one clock domain; the bench instantiates it beside the link interface
`timescale 1ns/1ps
module umaf_properties #(
  parameter int DIV_W = 12
) (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             dev_txd,
  input wire logic             rem_txd,
  input wire logic             send_valid,
  input wire logic             send_ready,
  input wire logic [2:0]       cfg_size,
  input wire logic             cfg_dspd,
  input wire logic             cfg_par,
  input wire logic [DIV_W-1:0] cfg_div,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // exact bit lengths only with the undivided tick and parity off; other settings go unchecked
  logic fast;
  assign fast = (cfg_div == '0) && !cfg_par;
  sequence s_clr_txc;
    psel && penable && pwrite && paddr == umaf_pkg::OFS_CSA && pwdata[umaf_pkg::A_TXC];
  endsequence
  sequence s_read_csa;
    psel && !penable && !pwrite && paddr == umaf_pkg::OFS_CSA;
  endsequence
  property p_reset_idle;
    $rose(presetn) |-> dev_txd && rem_txd && send_ready;
  endproperty
  property p_idle_high;
    send_ready |-> rem_txd;
  endproperty
  property p_take;
    send_valid && send_ready |=> !rem_txd && !send_ready;
  endproperty
  property p_start_norm;
    $fell(send_ready) && fast && !cfg_dspd |-> (!rem_txd)[*8] ##1 (!rem_txd)[*7];
  endproperty
  property p_start_dbl;
    $fell(send_ready) && fast && cfg_dspd |-> (!rem_txd)[*7];
  endproperty
  // one stop bit would end the frame at 112 clocks, two at 128
  property p_frame5;
    $fell(send_ready) && fast && !cfg_dspd && cfg_size == 3'h0
      |-> ##120 !send_ready ##[1:12] send_ready;
  endproperty
  property p_frame9;
    $fell(send_ready) && fast && !cfg_dspd && cfg_size == umaf_pkg::SIZE_9
      |-> ##168 !send_ready ##[1:12] send_ready;
  endproperty
  property p_clr_txc;
    s_clr_txc ##[1:3] s_read_csa |=> !prdata[umaf_pkg::A_TXC];
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("line not idle after reset");
  a_idle_high: assert property (p_idle_high) else $error("idle sender line low");
  a_take: assert property (p_take) else $error("request not taken at once");
  a_start_norm: assert property (p_start_norm) else $error("start bit too short");
  a_start_dbl: assert property (p_start_dbl) else $error("double speed start too short");
  a_frame5: assert property (p_frame5) else $error("five bit frame length wrong");
  a_frame9: assert property (p_frame9) else $error("nine bit frame length wrong");
  a_clr_txc: assert property (p_clr_txc) else $error("complete flag not cleared");
endmodule // umaf_properties

// [bench/uart_multidrop_address_filter_bench.sv]
// self-checking bench: node and remote sender joined by the link interface
// assumes the design package and both ends compiled first; pclk 200 MHz
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module uart_multidrop_address_filter_bench;
  localparam int DIV_W = 12;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic [2:0]       cfg_size = 3'h3;
  logic             cfg_dspd = 1'b0;
  logic             cfg_par = 1'b0;
  logic             cfg_podd = 1'b0;
  logic             cfg_stop2 = 1'b0;
  logic [DIV_W-1:0] cfg_div = '0;
  logic             send_valid = 1'b0;
  logic             send_ready;
  logic [8:0]       send_data = 9'h000;
  logic             send_addr = 1'b0;
  logic [31:0]      rd;
  logic             err;
  int               mismatches = 0;
  int               check_count = 0;
  int               cycles = 0;
  umaf_link_if link_if ();
  umaf_dev #(.DIV_W(DIV_W)) umaf_dev_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link_if.dev));
  umaf_rem #(.DIV_W(DIV_W)) umaf_rem_inst (.pclk(pclk), .presetn(presetn),
    .cfg_size(cfg_size), .cfg_dspd(cfg_dspd), .cfg_par(cfg_par), .cfg_podd(cfg_podd),
    .cfg_stop2(cfg_stop2), .cfg_div(cfg_div), .send_valid(send_valid),
    .send_ready(send_ready), .send_data(send_data), .send_addr(send_addr), .link(link_if.rem));
  umaf_properties #(.DIV_W(DIV_W)) umaf_properties_inst (.pclk(pclk), .presetn(presetn),
    .dev_txd(link_if.dev_txd), .rem_txd(link_if.rem_txd), .send_valid(send_valid),
    .send_ready(send_ready), .cfg_size(cfg_size), .cfg_dspd(cfg_dspd), .cfg_par(cfg_par),
    .cfg_div(cfg_div), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata));
  always #2.5 pclk = ~pclk;
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // a hang anywhere ends here; the full run needs about 1800 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic a, input logic [8:0] d);
    @(posedge pclk);
    send_valid <= 1'b1;
    send_addr <= a;
    send_data <= d;
    @(posedge pclk);
    send_valid <= 1'b0;
    @(posedge pclk);
    while (send_ready !== 1'b1) @(posedge pclk);
    repeat (4) @(posedge pclk);
  endtask
  // same size code on both ends, since one setting serves both directions
  task automatic setup(input logic [2:0] sz, input logic ds, input logic filt);
    cfg_size <= sz;
    cfg_dspd <= ds;
    apb(1'b1, umaf_pkg::OFS_CSB, {25'h0, sz, 4'hc});
    apb(1'b1, umaf_pkg::OFS_CSA, {30'h0, ds, filt});
  endtask
  task automatic rx_check(input logic kept, input logic [7:0] d);
    apb(1'b0, umaf_pkg::OFS_CSA, 32'h0);
    `CHK(rd[umaf_pkg::A_RXC], kept)
    if (kept) begin
      `CHK(rd[umaf_pkg::A_FE], 1'b0)
      `CHK({rd[umaf_pkg::A_UPE], rd[umaf_pkg::A_DOR]}, 2'b00)
      apb(1'b0, umaf_pkg::OFS_DATA, 32'h0);
      `CHK(rd[7:0], d)
    end
  endtask
  task automatic t_reset();
    apb(1'b0, umaf_pkg::OFS_CSA, 32'h0);
    `CHK(rd, 32'h20)
    apb(1'b0, umaf_pkg::OFS_CSB, 32'h0);
    `CHK(rd, {25'h0, umaf_pkg::SIZE_RST, 4'h0})
    apb(1'b0, 8'h10, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
  endtask
  task automatic t_nine();
    setup(umaf_pkg::SIZE_9, 1'b0, 1'b1);
    send(1'b0, 9'h0a5);
    rx_check(1'b0, 8'h00);
    send(1'b1, 9'h05a);
    apb(1'b0, umaf_pkg::OFS_CSB, 32'h0);
    `CHK(rd[umaf_pkg::B_RX9], 1'b1)
    rx_check(1'b1, 8'h5a);
    apb(1'b1, umaf_pkg::OFS_CSA, 32'h0);
    send(1'b0, 9'h0c3);
    apb(1'b0, umaf_pkg::OFS_CSB, 32'h0);
    `CHK(rd[umaf_pkg::B_RX9], 1'b0)
    rx_check(1'b1, 8'hc3);
    apb(1'b1, umaf_pkg::OFS_CSA, 32'h1);
    send(1'b0, 9'h011);
    rx_check(1'b0, 8'h00);
  endtask
  task automatic t_five();
    setup(3'h0, 1'b0, 1'b1);
    send(1'b0, 9'h00a);
    rx_check(1'b0, 8'h00);
    send(1'b1, 9'h015);
    rx_check(1'b1, 8'h15);
  endtask
  task automatic t_dbl();
    setup(umaf_pkg::SIZE_9, 1'b1, 1'b0);
    send(1'b0, 9'h0e7);
    rx_check(1'b1, 8'he7);
  endtask
  // ten-bit payload: nine bits plus odd parity, same on both ends
  task automatic t_par();
    cfg_par <= 1'b1;
    cfg_podd <= 1'b1;
    cfg_dspd <= 1'b0;
    apb(1'b1, umaf_pkg::OFS_CSB, {22'h0, 2'h3, 1'b0, umaf_pkg::SIZE_9, 4'hc});
    apb(1'b1, umaf_pkg::OFS_CSA, 32'h1);
    send(1'b1, 9'h0b4);
    apb(1'b0, umaf_pkg::OFS_CSB, 32'h0);
    `CHK(rd[umaf_pkg::B_RX9], 1'b1)
    rx_check(1'b1, 8'hb4);
    send(1'b0, 9'h069);
    rx_check(1'b0, 8'h00);
    cfg_par <= 1'b0;
  endtask
  // node sends with the filter on; its line must not care
  task automatic t_tx();
    logic [9:0] f;
    f = {1'b1, 8'h3c, 1'b0};
    setup(3'h3, 1'b0, 1'b1);
    apb(1'b1, umaf_pkg::OFS_DATA, 32'h3c);
    while (link_if.dev_txd !== 1'b0) @(posedge pclk);
    repeat (8) @(posedge pclk);
    for (int i = 0; i < 10; i++) begin
      `CHK(link_if.dev_txd, f[i])
      repeat (16) @(posedge pclk);
    end
    repeat (24) @(posedge pclk);
    apb(1'b0, umaf_pkg::OFS_CSA, 32'h0);
    `CHK(rd[umaf_pkg::A_TXC], 1'b1)
    apb(1'b1, umaf_pkg::OFS_CSA, 32'h41);
    apb(1'b0, umaf_pkg::OFS_CSA, 32'h0);
    `CHK({rd[umaf_pkg::A_TXC], rd[umaf_pkg::A_FILT]}, 2'b01)
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_nine();
    t_five();
    t_dbl();
    t_par();
    t_tx();
    stop_test();
  end
endmodule // uart_multidrop_address_filter_bench
